// ---- clock_sync_pkg.sv ----
//
// Purpose: Shared constants for the multi-chip clock synchronisation block.
// Assumes: core_clk is the sampling clock; classic Wishbone, 32-bit data.
// Notes:   Register indices are word indices; byte address is index times four.
//
package clock_sync_pkg;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [7:0] SYNC_CFG_INDEX = 8'h0C;
   localparam logic [7:0] SYNC_STATUS_INDEX = 8'h0D;
   localparam logic [7:0] SYNC_CFG_ADDR = 8'(SYNC_CFG_INDEX * 4);
   localparam logic [7:0] SYNC_STATUS_ADDR = 8'(SYNC_STATUS_INDEX * 4);
   localparam int ADDR_W = 8;
   localparam int CFG_W = 16;
   localparam logic [15:0] SYNC_CFG_RESET = 16'h0000;
   // Writable bits: delay code, phase select, role, output enable
   localparam logic [15:0] SYNC_CFG_WMASK = 16'hFF73;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int REF_OUT_EN_BIT = 0;
   localparam int FOLLOWER_BIT = 1;
   localparam int PHASE_LSB = 4;
   localparam int PHASE_MSB = 6;
   localparam int DELAY_LSB = 8;
   localparam int DELAY_MSB = 15;
   localparam int STAT_LOCKED_BIT = 0;
   localparam int STAT_UNSTABLE_BIT = 1;
   localparam int STAT_FOLLOWER_BIT = 2;

   // ***************************************************************
   // Clock ratios and timing
   // ***************************************************************
   localparam logic [5:0] REF_DIV = 6'h28;
   localparam logic [5:0] REF_HALF = 6'h14;
   localparam logic [2:0] OUTPUT_DATA_CLOCK_HALF = 3'h4;
   localparam logic [2:0] PHASE_RISE = 3'h0;
   // Divider value at the cycle after the filtered reference edge
   localparam logic [5:0] REF_ALIGN_CNT = 6'h03;
   localparam int DELAY_MAX_PS = 400;
   localparam int CORE_PERIOD_NS = 50;
   // Lock lost after two reference periods with no edge
   localparam logic [7:0] LOCK_TIMEOUT = 8'(2 * REF_DIV);

   typedef enum logic [1:0] {
      ROLE_LEADER = 2'b00,
      ROLE_FOLLOW_WAIT = 2'b01,
      ROLE_FOLLOW_LOCK = 2'b11
   } role_state_t;

endpackage : clock_sync_pkg

// ---- clock_sync_ctrl.sv ----
//
// Purpose: Leader/follower reference clock logic with data clock alignment.
// Assumes: Reference input is asynchronous but of the same source as core_clk.
// Notes:   The analog input delay is modelled as regions of codes.
//
import clock_sync_pkg::*;

module clock_sync_ctrl #(
   parameter int DATA_W = 10,
   parameter int LATENCY = 16,
   parameter int REGION_SPAN = 64,
   parameter int UNSTABLE_W = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [clock_sync_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic reference_input_pair_p,
   input wire logic reference_input_pair_n,
   output logic [1:0] ref_clock_outputs,
   output logic output_data_clock,
   input wire logic [DATA_W-1:0] sample_data,
   output logic [DATA_W-1:0] output_data,
   output logic sync_locked
);
   import clock_sync_pkg::*;

   // ***************************************************************
   // Helper functions
   // ***************************************************************

   // Codes near a region boundary cannot be captured cleanly
   function automatic logic code_unstable(input logic [7:0] code);
      int rem;
      rem = int'(code) % REGION_SPAN;
      return (int'(code) >= REGION_SPAN) && (rem < UNSTABLE_W);
   endfunction : code_unstable

   // Stable region index, one data clock eighth per region
   function automatic logic [2:0] code_region(input logic [7:0] code);
      return 3'(int'(code) / REGION_SPAN);
   endfunction : code_region

   // ***************************************************************
   // Register and bus state
   // ***************************************************************
   logic [CFG_W-1:0] sync_reference_config;
   logic [CFG_W-1:0] next_cfg;
   logic [CFG_W-1:0] wr_lanes;
   logic bus_req;
   logic wr_cfg;
   logic [7:0] ref_delay_setting;
   logic [2:0] output_clock_phase_select;
   logic ref_output_enable;
   logic follower;
   role_state_t role_state;
   logic [5:0] div_cnt;
   logic [7:0] lock_cnt;
   logic [2:0] lag;
   logic [2:0] output_data_clock_phase;
   logic unstable;
   logic ref_s1;
   logic ref_s2;
   logic ref_s3;
   logic ref_level;
   logic ref_rise;
   logic [DATA_W-1:0] pipe [LATENCY];
   logic [7:0] fill_cnt;

   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_cfg = bus_req && wb_we_i && (wb_adr_i == SYNC_CFG_ADDR);
   assign wr_lanes = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign ref_delay_setting = sync_reference_config[DELAY_MSB:DELAY_LSB];
   assign output_clock_phase_select = sync_reference_config[PHASE_MSB:PHASE_LSB];
   assign ref_output_enable = sync_reference_config[REF_OUT_EN_BIT];
   assign follower = sync_reference_config[FOLLOWER_BIT];
   assign unstable = follower && code_unstable(ref_delay_setting);

   // Byte lanes merge into the writable bits only
   always_comb begin
      next_cfg = sync_reference_config;
      next_cfg = (sync_reference_config & ~(wr_lanes & SYNC_CFG_WMASK))
         | (wb_dat_i[CFG_W-1:0] & wr_lanes & SYNC_CFG_WMASK);
   end

   // ***************************************************************
   // Wishbone slave
   // ***************************************************************

   // Ack one cycle after the request, dropped in the next
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // Read data; unmapped words read as zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (bus_req && !wb_we_i) begin
         case (wb_adr_i)
            SYNC_CFG_ADDR: begin
               wb_dat_o <= {16'h0000, sync_reference_config};
            end
            SYNC_STATUS_ADDR: begin
               wb_dat_o <= 32'h0000_0000;
               wb_dat_o[STAT_LOCKED_BIT] <= sync_locked;
               wb_dat_o[STAT_UNSTABLE_BIT] <= unstable;
               wb_dat_o[STAT_FOLLOWER_BIT] <= follower;
            end
            default: begin
               wb_dat_o <= 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync_reference_config <= SYNC_CFG_RESET;
      end else if (wr_cfg) begin
         sync_reference_config <= next_cfg;
      end
   end

   // ***************************************************************
   // Reference input synchroniser
   // ***************************************************************

   // Three stages; a level counts once stages two and three agree
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ref_s1 <= 1'b0;
         ref_s2 <= 1'b0;
         ref_s3 <= 1'b0;
         ref_level <= 1'b0;
      end else begin
         ref_s1 <= reference_input_pair_p && !reference_input_pair_n;
         ref_s2 <= ref_s1;
         ref_s3 <= ref_s2;
         if (ref_s2 == ref_s3) begin
            ref_level <= ref_s3;
         end
      end
   end

   assign ref_rise = (ref_s2 == ref_s3) && ref_s3 && !ref_level;

   // ***************************************************************
   // Divider and role tracking
   // ***************************************************************

   // leader free-runs from the sampling clock
   // follower snaps the divider to the reference edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         div_cnt <= 6'h00;
      end else if (follower && ref_rise) begin
         div_cnt <= REF_ALIGN_CNT;
      end else if (div_cnt == REF_DIV - 6'h01) begin
         div_cnt <= 6'h00;
      end else begin
         div_cnt <= div_cnt + 6'h01;
      end
   end

   // role follows bit 1; lock needs a recent reference edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         role_state <= ROLE_LEADER;
         lock_cnt <= 8'h00;
      end else begin
         case (role_state)
            ROLE_LEADER: begin
               lock_cnt <= 8'h00;
               if (follower) begin
                  role_state <= ROLE_FOLLOW_WAIT;
               end
            end
            ROLE_FOLLOW_WAIT: begin
               lock_cnt <= 8'h00;
               if (!follower) begin
                  role_state <= ROLE_LEADER;
               end else if (ref_rise) begin
                  role_state <= ROLE_FOLLOW_LOCK;
               end
            end
            ROLE_FOLLOW_LOCK: begin
               lock_cnt <= ref_rise ? 8'h00 : lock_cnt + 8'h01;
               if (!follower) begin
                  role_state <= ROLE_LEADER;
               end else if (lock_cnt >= LOCK_TIMEOUT) begin
                  role_state <= ROLE_FOLLOW_WAIT;
               end
            end
            default: begin
               role_state <= ROLE_LEADER;
               lock_cnt <= 8'h00;
            end
         endcase
      end
   end

   // Lock flag; a leader aligns to nobody after reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync_locked <= 1'b0;
      end else begin
         sync_locked <= (role_state == ROLE_FOLLOW_LOCK);
      end
   end

   // ***************************************************************
   // Reference outputs
   // ***************************************************************

   // both outputs at data clock / 5 when enabled
   // taken from the divider, not the phase lag
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ref_clock_outputs <= 2'b00;
      end else begin
         ref_clock_outputs <= {2{ref_output_enable && (div_cnt < REF_HALF)}};
      end
   end

   // ***************************************************************
   // Data clock and data path
   // ***************************************************************

   // phase select adds 45 degree steps
   // delay code picks the capture region
   // each later region adds one more step of lag
   assign lag = follower ? 3'(output_clock_phase_select + code_region(ref_delay_setting))
      : 3'h0;
   assign output_data_clock_phase = 3'(div_cnt[2:0] - lag);

   // unstable region holds the clock high
   always_ff @(posedge core_clk) begin
      if (rst) begin
         output_data_clock <= 1'b0;
      end else if (unstable) begin
         output_data_clock <= 1'b1;
      end else begin
         output_data_clock <= (output_data_clock_phase < OUTPUT_DATA_CLOCK_HALF);
      end
   end

   // fixed pipeline depth from sample to output
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < LATENCY; i++) begin
            pipe[i] <= '0;
         end
      end else begin
         pipe[0] <= sample_data;
         for (int i = 1; i < LATENCY; i++) begin
            pipe[i] <= pipe[i-1];
         end
      end
   end

   // Pipeline fill count; reset clears the pipe, so it is only full later
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fill_cnt <= 8'h00;
      end else if (fill_cnt < 8'(LATENCY)) begin
         fill_cnt <= fill_cnt + 8'h01;
      end
   end

   // data launched on the same phase as the data clock
   always_ff @(posedge core_clk) begin
      if (rst) begin
         output_data <= '0;
      end else if (!unstable && output_data_clock_phase == PHASE_RISE) begin
         output_data <= pipe[LATENCY-1];
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence leader_high_s;
      output_data_clock [*4];
   endsequence
   sequence leader_low_s;
      !output_data_clock [*4];
   endsequence
   sequence cfg_write_s;
      wr_cfg;
   endsequence

   role_align_a: assert property (follower && ref_rise |=> div_cnt == REF_ALIGN_CNT)
      else $error("follower divider not aligned to reference edge");

   ref_out_off_a: assert property (!ref_output_enable |=> ref_clock_outputs == 2'b00)
      else $error("reference outputs drive while disabled");

   ref_out_wave_a: assert property (ref_output_enable && $stable(ref_output_enable)
      && div_cnt == 6'h00 && !(follower && ref_rise) && (!follower || sync_locked)
      |=> ref_clock_outputs == 2'b11 ##20 ref_clock_outputs == 2'b00)
      else $error("reference output square wave wrong");

   leader_output_data_clock_a: assert property (!follower && $stable(sync_reference_config)
      && $rose(output_data_clock) |-> leader_high_s ##0 1'b1 ##1 leader_low_s)
      else $error("leader data clock not one eighth of sampling clock");

   unstable_high_a: assert property (unstable ##1 unstable |-> output_data_clock)
      else $error("data clock toggles in unstable region");

   reserved_zero_a: assert property (cfg_write_s |=> sync_reference_config[7] == 1'b0
      && sync_reference_config[3:2] == 2'b00)
      else $error("reserved configuration bits were written");

   cfg_apply_a: assert property (cfg_write_s ##0 (wb_sel_i[1:0] == 2'b11)
      |=> sync_reference_config == $past(wb_dat_i[CFG_W-1:0] & SYNC_CFG_WMASK))
      else $error("configuration write did not take effect");

   latency_fix_a: assert property (fill_cnt >= 8'(LATENCY)
      |-> pipe[LATENCY-1] == $past(sample_data, LATENCY))
      else $error("sample latency not fixed");

   reset_leader_a: assert property ($past(rst) |-> sync_reference_config == SYNC_CFG_RESET
      && !sync_locked)
      else $error("reset did not restore leader defaults");

   role_leave_a: assert property (!follower ##1 !follower |-> role_state == ROLE_LEADER)
      else $error("role state not leader while bit 1 clear");

   phase_lag_a: assert property (follower && !unstable && $stable(lag) && $stable(div_cnt)
      == 1'b0 && div_cnt[2:0] == lag && !ref_rise |=> output_data_clock)
      else $error("data clock phase does not match phase select");

endmodule : clock_sync_ctrl

// ---- ref_source.sv ----
//
// Purpose: Reference clock source standing in for a leader converter.
// Assumes: Same source as core_clk; square wave of 40 sampling cycles.
// Notes:   Held still low while stopped, as a disabled driver would be.
//
module ref_source (
   input wire logic core_clk,
   input wire logic run,
   output logic ref_p = 1'b0,
   output logic ref_n = 1'b1
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned phase_cnt = 0;

   always @(posedge core_clk) begin
      phase_cnt <= (!run || phase_cnt == 39) ? 0 : phase_cnt + 1;
      ref_p <= run && phase_cnt < 20;
      ref_n <= !(run && phase_cnt < 20);
   end
endmodule : ref_source

// ---- tb_top.sv ----
//
// Purpose: Self-checking bench for the clock synchronisation block.
// Assumes: Wishbone ack comes one cycle after the request is taken.
// Notes:   Phase checks are relative to a first measured lag, so the
//          fixed pipeline offset of the divider does not matter.
//
module tb_top;
   import clock_sync_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic ref_p;
   logic ref_n;
   logic run = 1'b0;
   logic [1:0] ref_clock_outputs;
   logic output_data_clock;
   logic [9:0] sample_data = 10'h000;
   logic [9:0] output_data;
   logic sync_locked;
   int failures = 0;
   int comparisons = 0;
   logic [31:0] q, d, exp, base, x, a, b, c, e;
   logic [3:0] s;
   logic [7:0] codes [3] = '{8'd80, 8'd140, 8'd200};

   always #25 core_clk = ~core_clk;

   // Fresh samples every cycle keep the data path busy
   always @(posedge core_clk) sample_data <= 10'($urandom);

   clock_sync_ctrl i_clock_sync_ctrl (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .reference_input_pair_p(ref_p), .reference_input_pair_n(ref_n),
      .ref_clock_outputs(ref_clock_outputs), .output_data_clock(output_data_clock),
      .sample_data(sample_data), .output_data(output_data), .sync_locked(sync_locked));

   ref_source i_ref_source (.core_clk(core_clk), .run(run), .ref_p(ref_p), .ref_n(ref_n));

   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic compare(input logic [63:0] got, input logic [63:0] want, input string what);
      comparisons++;
      if (got !== want) begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, want);
      end
   endtask : compare

   // Holds the request until ack is sampled high, then releases
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      input logic [3:0] sel, output logic [31:0] rdat);
      int n;
      n = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (n >= 20) failures++;
      @(posedge core_clk);
   endtask : bus

   task automatic set_cfg(input logic [15:0] v);
      logic [31:0] r;
      bus(1'b1, SYNC_CFG_ADDR, {16'h0000, v}, 4'h3, r);
   endtask : set_cfg

   // Counts high cycles and rising edges of both clock outputs
   task automatic window(output logic [31:0] rh, output logic [31:0] rr,
                         output logic [31:0] ch, output logic [31:0] cr);
      logic pr, pc;
      rh = 0;
      rr = 0;
      ch = 0;
      cr = 0;
      #1 pr = ref_clock_outputs[0];
      pc = output_data_clock;
      repeat (80) begin
         @(posedge core_clk);
         #1;
         compare(64'(ref_clock_outputs[1]), 64'(ref_clock_outputs[0]), "ref pair");
         rh += ref_clock_outputs[0];
         rr += !pr && ref_clock_outputs[0];
         ch += output_data_clock;
         cr += !pc && output_data_clock;
         pr = ref_clock_outputs[0];
         pc = output_data_clock;
      end
   endtask : window

   // Cycles from a reference rise to the next data clock rise, modulo 8
   task automatic lag(output logic [31:0] l);
      int n;
      logic pc;
      n = 0;
      @(posedge ref_p);
      #1 pc = output_data_clock;
      do begin
         pc = output_data_clock;
         @(posedge core_clk);
         #1 n++;
      end while (!(pc === 1'b0 && output_data_clock === 1'b1) && n < 20);
      l = 32'(n % 8);
   endtask : lag

   function automatic logic [31:0] cfg_model(logic [31:0] old, logic [31:0] w, logic [3:0] m);
      logic [31:0] r;
      r = old;
      if (m[0]) r[7:0] = w[7:0] & 8'h73;
      if (m[1]) r[15:8] = w[15:8];
      return r;
   endfunction : cfg_model

   task automatic final_report;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      void'($urandom(49));
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      bus(1'b0, SYNC_CFG_ADDR, 32'h0, 4'hF, q);
      compare(q, 32'h0, "config after reset");
      window(a, b, c, e);
      compare({a, b}, 64'h0, "ref outputs off");
      compare(c, 32'd40, "leader data clock high");
      compare(e, 32'd10, "leader data clock rises");
      compare(64'(sync_locked), 64'h0, "leader unlocked");
      exp = 32'h0;
      repeat (8) begin
         d = $urandom;
         s = 4'($urandom);
         bus(1'b1, SYNC_CFG_ADDR, d, s, q);
         exp = cfg_model(exp, d, s);
         bus(1'b0, SYNC_CFG_ADDR, 32'h0, 4'hF, q);
         compare(q, exp, "config readback");
      end
      bus(1'b1, 8'h38, $urandom, 4'hF, q);
      bus(1'b0, 8'h38, 32'h0, 4'hF, q);
      compare(q, 32'h0, "unmapped read");
      set_cfg(16'h0001);
      window(a, b, c, e);
      compare({a, b}, {32'd40, 32'd2}, "leader ref out");
      // Lock first with outputs off, so the first divider snap cuts no wave
      run <= 1'b1;
      set_cfg(16'h0002);
      repeat (200) @(posedge core_clk);
      compare(64'(sync_locked), 64'h1, "follower locked");
      bus(1'b0, SYNC_STATUS_ADDR, 32'h0, 4'hF, q);
      compare(q, 32'h5, "status locked follower");
      set_cfg(16'h0003);
      window(a, b, c, e);
      compare({a, b}, {32'd40, 32'd2}, "follower ref out");
      compare({c, e}, {32'd40, 32'd10}, "follower data clock");
      lag(base);
      for (int p = 1; p < 8; p++) begin
         set_cfg({8'h00, 1'b0, 3'(p), 4'h3});
         repeat (120) @(posedge core_clk);
         lag(x);
         compare(x, 32'((base + p) % 8), "phase step");
      end
      for (int r = 0; r < 3; r++) begin
         set_cfg({codes[r], 8'h03});
         repeat (120) @(posedge core_clk);
         lag(x);
         compare(x, 32'((base + r + 1) % 8), "stable region lag");
      end
      set_cfg(16'h4003);
      repeat (120) @(posedge core_clk);
      window(a, b, c, e);
      compare({c, e}, {32'd80, 32'd0}, "unstable held high");
      bus(1'b0, SYNC_STATUS_ADDR, 32'h0, 4'hF, q);
      compare(q, 32'h7, "status unstable");
      final_report();
   end

   // Watchdog well beyond the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      final_report();
   end
endmodule : tb_top
